// >>> drive_model.sv
// drive interface model: echoes the commanded speed of each called pump
// assumes one speed word per pump, percent of full scale
module drive_model
    import vfd_speed_pkg::*;
(
    input  wire logic                          clk_sys,
    input  wire logic                          reset_n,
    input  wire logic [PUMPS-1:0]              pumpRun,
    input  wire logic [PUMPS-1:0][SPEED_W-1:0] speedCmd,
    output logic      [PUMPS-1:0][SPEED_W-1:0] fbSpeed
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle pumps report zero, never a stale speed
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            fbSpeed <= '0;
        else
            for (int k = 0; k < PUMPS; k++)
                fbSpeed[k] <= pumpRun[k] ? speedCmd[k] : SPEED_ZERO;
    end
endmodule

// >>> pump_ramp.sv
// one pump: speed ramp and minimum-run timer
// assumes accelTick and secTick are single-cycle pulses from the top
module pump_ramp
    import vfd_speed_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                reset_n,
    input  wire logic                run,
    input  wire logic [SPEED_W-1:0]  target,
    input  wire logic [SPEED_W-1:0]  accel,
    input  wire logic                accelTick,
    input  wire logic                secTick,
    input  wire logic [RUNSEC_W-1:0] minRunSec,
    output logic      [SPEED_W-1:0]  speed,
    output logic                     minRunDone
);

    typedef struct packed {
        logic [SPEED_W-1:0]  speed;
        logic [RUNSEC_W-1:0] runSec;
        logic                done;
    } ramp_t;

    ramp_t state;
    ramp_t next_state;
    logic [SPEED_W:0] sum;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        sum = {1'b0, state.speed} + {1'b0, accel};
        if (!run)
        begin
            next_state = '0;
        end
        else
        begin
            if (state.speed > target)
                next_state.speed = target;
            else if (accelTick)
                next_state.speed = (sum > {1'b0, target}) ? target : sum[SPEED_W-1:0];
            if (secTick && state.runSec != '1)
                next_state.runSec = state.runSec + RUNSEC_W'(1);
            next_state.done = (next_state.runSec >= minRunSec);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            state <= '0;
        else
            state <= next_state;
    end

    assign speed      = state.speed;
    assign minRunDone = state.done;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_ramp_step: assert property (
        run && $past(run) && $past(state.speed) <= $past(target)
        |-> {1'b0, state.speed} <= {1'b0, $past(state.speed)} + {1'b0, $past(accel)})
        else $error("ramp rose faster than the acceleration step");
    a_stop_zero: assert property (
        !run |=> state.speed == SPEED_ZERO)
        else $error("stopped pump kept a speed");
    a_minrun_done: assert property (
        state.done |-> state.runSec >= minRunSec)
        else $error("minimum run flagged early");

endmodule

// >>> pump_speed_staging.sv
// speed and staging controller for up to three variable-speed pumps
// assumes all inputs synchronous to clk_sys; adjust/config inputs are 1-cycle pulses
import vfd_speed_pkg::*;

module pump_speed_staging
    import vfd_speed_pkg::*;
#(
    parameter int SEC_CYCLES = SECOND_CYCLES
)
(
    input  wire logic                           clk_sys,
    input  wire logic                           reset_n,
    input  wire logic [LEVEL_W-1:0]             wellLevel,
    input  wire logic [LEVEL_W-1:0]             procSetpoint,
    input  wire logic [LEVEL_W-1:0]             leadStartLevel,
    input  wire logic [LEVEL_W-1:0]             lagStartLevel,
    input  wire logic [LEVEL_W-1:0]             secondLagStartLevel,
    input  wire logic [LEVEL_W-1:0]             leadStopLevel,
    input  wire logic [LEVEL_W-1:0]             lagStopLevel,
    input  wire logic [LEVEL_W-1:0]             secondLagStopLevel,
    input  wire logic [SPEED_W-1:0]             minSpeed,
    input  wire logic [SPEED_W-1:0]             maxSpeed,
    input  wire logic [SPEED_W-1:0]             stageOffSpeed,
    input  wire staging_t                       stagingMode,
    input  wire logic [RUNSEC_W-1:0]            minRunSec,
    input  wire logic [PUMPS-1:0][SPEED_W-1:0]  accel,
    input  wire logic [PUMPS-1:0]               handSelect,
    input  wire logic [PUMPS-1:0]               telemetryForce,
    input  wire logic                           fixedLagEnable,
    input  wire faultMode_t                     transducerFaultMode,
    input  wire logic                           highFloatEnable,
    input  wire logic                           lowFloatEnable,
    input  wire logic                           highFloat,
    input  wire logic                           lowFloat,
    input  wire logic                           adjUpCoarse,
    input  wire logic                           adjUpFine,
    input  wire logic                           adjDownFine,
    input  wire logic                           adjDownCoarse,
    input  wire logic                           adjApply,
    input  wire logic                           adjRevert,
    input  wire logic                           adjSave,
    input  wire logic                           processRestart,
    input  wire logic                           configWrite,
    input  wire logic [SPEED_W-1:0]             configSpeed,
    input  wire logic                           driveEnable,
    input  wire logic                           driveDisable,
    input  wire logic                           factoryReset,
    output logic      [PUMPS-1:0]               pumpRun,
    output logic      [PUMPS-1:0][SPEED_W-1:0]  speedCmd,
    output logic      [SPEED_W-1:0]             pendingSpeed,
    output logic      [SPEED_W-1:0]             activeSpeed,
    output logic      [SPEED_W-1:0]             storedSpeed,
    output logic                                driveMode
);

    typedef struct packed {
        logic [SECCNT_W-1:0] secCount;
        logic                secTick;
        logic [ACCCNT_W-1:0] accelCount;
        logic                accelTick;
        logic [PUMPS-1:0]    run;
        logic [SPEED_W-1:0]  pending;
        logic [SPEED_W-1:0]  active;
        logic [SPEED_W-1:0]  stored;
        logic                driveMode;
    } ctrl_t;

    ctrl_t                           state;
    ctrl_t                           next_state;
    logic [PUMPS-1:0][LEVEL_W-1:0]   startLvl;
    logic [PUMPS-1:0][LEVEL_W-1:0]   stopLvl;
    logic [PUMPS-1:0][SPEED_W-1:0]   targetSpeed;
    logic [PUMPS-1:0]                minRunDone;
    logic [LEVEL_W-1:0]              maxLevel;
    logic [SPEED_W-1:0]              autoSpeed;
    logic                            highCall;
    logic                            lowKill;
    logic                            overrideAll;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [SPEED_W-1:0] interp(
        input logic [LEVEL_W-1:0] level,
        input logic [LEVEL_W-1:0] lo,
        input logic [LEVEL_W-1:0] hi,
        input logic [SPEED_W-1:0] minS,
        input logic [SPEED_W-1:0] maxS
    );
        logic [SPEED_W+LEVEL_W-1:0] prod;
        logic [SPEED_W-1:0]         res;
        prod = '0;
        res  = minS;
        if (maxS <= minS || level <= lo)
            res = minS;
        else if (level >= hi || hi <= lo)
            res = maxS;
        else
        begin
            prod = (maxS - minS) * (level - lo);
            res  = minS + SPEED_W'(prod / (hi - lo));
        end
        return res;
    endfunction

    function automatic logic [SPEED_W-1:0] stepSpeed(
        input logic [SPEED_W-1:0] cur,
        input logic [SPEED_W-1:0] step,
        input logic               down
    );
        logic [SPEED_W:0] up;
        logic [SPEED_W-1:0] res;
        up  = {1'b0, cur} + {1'b0, step};
        res = cur;
        if (down)
            res = (cur > step) ? cur - step : SPEED_ZERO;
        else
            res = (up > {1'b0, SPEED_FULL}) ? SPEED_FULL : up[SPEED_W-1:0];
        return res;
    endfunction

    // ------------------------------------------------------------
    // speed targets
    // ------------------------------------------------------------
    assign startLvl = {secondLagStartLevel, lagStartLevel, leadStartLevel};
    assign stopLvl  = {secondLagStopLevel, lagStopLevel, leadStopLevel};

    // floats act in disabled-backup mode only
    assign highCall = highFloatEnable && highFloat
                      && transducerFaultMode == FAULT_DISABLED_BACKUP;
    assign lowKill  = lowFloatEnable && !lowFloat
                      && transducerFaultMode == FAULT_DISABLED_BACKUP;
    assign overrideAll = (|handSelect) || (|telemetryForce) || highCall;

    // threshold for max speed rises once the lag pump runs
    assign maxLevel  = state.run[1] ? secondLagStartLevel : lagStartLevel;
    assign autoSpeed = interp(wellLevel, procSetpoint, maxLevel,
                              minSpeed, maxSpeed);

    always_comb
    begin
        for (int k = 0; k < PUMPS; k++)
        begin
            targetSpeed[k] = autoSpeed;
            if (overrideAll || (k == PUMPS - 1 && fixedLagEnable))
                targetSpeed[k] = state.active;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_state.secTick   = 1'b0;
        next_state.accelTick = 1'b0;
        if (state.secCount == SECCNT_W'(SEC_CYCLES - 1))
        begin
            next_state.secCount = '0;
            next_state.secTick  = 1'b1;
            if (state.accelCount == ACCCNT_W'(ACCEL_INTERVAL_S - 1))
            begin
                next_state.accelCount = '0;
                next_state.accelTick  = 1'b1;
            end
            else
                next_state.accelCount = state.accelCount + ACCCNT_W'(1);
        end
        else
            next_state.secCount = state.secCount + SECCNT_W'(1);

        for (int k = 0; k < PUMPS; k++)
        begin
            if (!state.run[k])
                next_state.run[k] = wellLevel >= startLvl[k];
            else if (stagingMode == STAGE_LEVEL)
                next_state.run[k] = wellLevel > stopLvl[k];
            else
                next_state.run[k] = !(speedCmd[k] <= stageOffSpeed
                                      && wellLevel <= startLvl[k]
                                      && minRunDone[k]);
            if (handSelect[k] || telemetryForce[k] || highCall)
                next_state.run[k] = 1'b1;
            if ((lowKill && !highCall) || !state.driveMode)
                next_state.run[k] = 1'b0;
        end

        // manual speed adjustment, one action per cycle
        if (processRestart)
        begin
            next_state.active  = state.stored;
            next_state.pending = state.stored;
        end
        else if (adjApply)
            next_state.active = state.pending;
        else if (adjRevert)
            next_state.pending = state.stored;
        else if (adjSave)
            next_state.stored = state.active;
        else if (configWrite)
        begin
            next_state.stored  = configSpeed;
            next_state.active  = configSpeed;
            next_state.pending = configSpeed;
        end
        else if (adjUpCoarse)
            next_state.pending = stepSpeed(state.pending, STEP_COARSE, 1'b0);
        else if (adjUpFine)
            next_state.pending = stepSpeed(state.pending, STEP_FINE, 1'b0);
        else if (adjDownFine)
            next_state.pending = stepSpeed(state.pending, STEP_FINE, 1'b1);
        else if (adjDownCoarse)
            next_state.pending = stepSpeed(state.pending, STEP_COARSE, 1'b1);

        // drive mode kept across process restarts
        if (factoryReset)
        begin
            next_state.driveMode = DRIVE_RST;
            next_state.stored    = OVERRIDE_RST;
            next_state.active    = OVERRIDE_RST;
            next_state.pending   = OVERRIDE_RST;
        end
        else if (driveEnable)
            next_state.driveMode = 1'b1;
        else if (driveDisable)
            next_state.driveMode = 1'b0;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state           <= '0;
            state.pending   <= OVERRIDE_RST;
            state.active    <= OVERRIDE_RST;
            state.stored    <= OVERRIDE_RST;
            state.driveMode <= DRIVE_RST;
        end
        else
            state <= next_state;
    end

    // ------------------------------------------------------------
    // per-pump ramps
    // ------------------------------------------------------------
    for (genvar g = 0; g < PUMPS; g++)
    begin : gen_pump
        pump_ramp u_ramp (
            .clk_sys    (clk_sys),
            .reset_n    (reset_n),
            .run        (state.run[g]),
            .target     (targetSpeed[g]),
            .accel      (accel[g]),
            .accelTick  (state.accelTick),
            .secTick    (state.secTick),
            .minRunSec  (minRunSec),
            .speed      (speedCmd[g]),
            .minRunDone (minRunDone[g])
        );
    end

    assign pumpRun      = state.run;
    assign pendingSpeed = state.pending;
    assign activeSpeed  = state.active;
    assign storedSpeed  = state.stored;
    assign driveMode    = state.driveMode;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_lead_start: assert property (
        state.driveMode && !lowKill && wellLevel >= leadStartLevel
        && (stagingMode == STAGE_LEVEL || wellLevel > leadStartLevel) |=> pumpRun[0])
        else $error("lead pump not started at lead start level");
    a_low_kill: assert property (
        lowKill && !highCall ##1 lowKill |-> pumpRun == '0 ##1 speedCmd[0] == SPEED_ZERO)
        else $error("pumps not stopped by low float");
    a_high_all: assert property (
        highCall && state.driveMode |=> pumpRun == '1)
        else $error("high float did not call all pumps");
    a_hand_speed: assert property (
        |handSelect |-> targetSpeed[0] == activeSpeed && targetSpeed[1] == activeSpeed)
        else $error("hand selection did not force manual speed");
    a_fixed_lag: assert property (
        fixedLagEnable |-> targetSpeed[PUMPS-1] == activeSpeed)
        else $error("fixed lag pump not at manual speed");
    a_auto_limits: assert property (
        !overrideAll && minSpeed <= maxSpeed
        |-> targetSpeed[0] >= minSpeed && targetSpeed[0] <= maxSpeed)
        else $error("automatic speed outside limits");
    a_apply_pending: assert property (
        adjApply && !processRestart && !factoryReset |=> activeSpeed == $past(pendingSpeed))
        else $error("apply did not commit pending speed");
    a_save_stored: assert property (
        adjSave && !processRestart && !adjApply && !adjRevert && !factoryReset
        |=> storedSpeed == $past(activeSpeed))
        else $error("save did not store the applied speed");
    a_factory_mode: assert property (
        factoryReset |=> !driveMode ##1 pumpRun == '0)
        else $error("factory reset left drive mode on");

endmodule

// >>> tb.sv
// self-checking bench for the pump speed and staging controller
// assumes SEC_CYCLES shortened to 2, so an acceleration step every 10 cycles
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import vfd_speed_pkg::*;
    typedef struct {int id; logic [11:0] v;} note_t;
    logic                          clk_sys, reset_n, fixedLag, hiEn, loEn, hiF, loF;
    logic [LEVEL_W-1:0]            level, setp, leadStop;
    logic [RUNSEC_W-1:0]           minRun;
    logic [SPEED_W-1:0]            stgOff, cfgSpd;
    faultMode_t                    fMode;
    logic [PUMPS-1:0][SPEED_W-1:0] accel, fbSpeed, speedCmd;
    logic [PUMPS-1:0]              hand, tele, pumpRun;
    logic [SPEED_W-1:0]            minS, maxS, pend, act, stored;
    logic [11:0]                   adj;
    logic                          driveMode;
    staging_t                      stg;
    int                            failures, cmp_count, seed;
    note_t                         notes[$];
    string                         nm[9] = '{"pending", "active", "stored", "driveMode",
                                             "pumpRun", "speed0", "speed1", "speed2", "fb0"};
    pump_speed_staging #(.SEC_CYCLES(2)) pump_speed_staging_i (.clk_sys(clk_sys),
        .reset_n(reset_n), .wellLevel(level), .procSetpoint(setp),
        .leadStartLevel(12'h0C8), .lagStartLevel(12'h12C), .secondLagStartLevel(12'h190),
        .leadStopLevel(leadStop), .lagStopLevel(12'h0FA), .secondLagStopLevel(12'h15E),
        .minSpeed(minS), .maxSpeed(maxS), .stageOffSpeed(stgOff), .stagingMode(stg),
        .minRunSec(minRun), .accel(accel), .handSelect(hand), .telemetryForce(tele),
        .fixedLagEnable(fixedLag), .transducerFaultMode(fMode),
        .highFloatEnable(hiEn), .lowFloatEnable(loEn), .highFloat(hiF), .lowFloat(loF),
        .adjUpCoarse(adj[0]), .adjUpFine(adj[1]), .adjDownFine(adj[2]),
        .adjDownCoarse(adj[3]), .adjApply(adj[4]), .adjRevert(adj[5]), .adjSave(adj[6]),
        .processRestart(adj[7]), .configWrite(adj[8]), .configSpeed(cfgSpd),
        .driveEnable(adj[9]), .driveDisable(adj[10]), .factoryReset(adj[11]),
        .pumpRun(pumpRun), .speedCmd(speedCmd), .pendingSpeed(pend), .activeSpeed(act),
        .storedSpeed(stored), .driveMode(driveMode));
    drive_model drive_model_i (.clk_sys(clk_sys), .reset_n(reset_n), .pumpRun(pumpRun),
        .speedCmd(speedCmd), .fbSpeed(fbSpeed));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // scoreboard
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [11:0] observed(input int id);
        case (id)
            0: return 12'(pend);
            1: return 12'(act);
            2: return 12'(stored);
            3: return 12'(driveMode);
            4: return 12'(pumpRun);
            8: return 12'(fbSpeed[0]);
            default: return 12'(speedCmd[id-5]);
        endcase
    endfunction

    always @(negedge clk_sys)
        while (notes.size() > 0)
        begin
            note_t c;
            c = notes.pop_front();
            check(nm[c.id], observed(c.id), c.v);
        end

    task automatic note(input int id, input logic [11:0] v);
        notes.push_back('{id, v});
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask

    // wait until the cared-for speed words reach their targets
    task automatic settle(input logic [PUMPS-1:0][SPEED_W-1:0] want,
                          input logic [PUMPS-1:0][SPEED_W-1:0] care);
        int waited;
        waited = 0;
        while (((speedCmd ^ want) & care) !== '0 && waited < 3000)
        begin
            tick(1);
            waited++;
        end
        if (waited == 3000)
            failures++;
    endtask

    task automatic pulse(input int b);
        @(posedge clk_sys);
        adj <= 12'h001 << b;
        @(posedge clk_sys);
        adj <= 12'h000;
    endtask

    task automatic give_verdict;
        if (failures == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #300000;
        failures++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        int steps[4] = '{5, 1, -1, -5};
        logic [11:0] p;
        seed = 32'h65aa;
        reset_n = 1'b0; level = 12'h000; minS = 7'h3C; maxS = 7'h3C; stg = STAGE_LEVEL;
        accel = '0; hand = '0; tele = '0; fixedLag = 1'b0; hiEn = 1'b1; loEn = 1'b0;
        hiF = 1'b0; loF = 1'b1; adj = 12'h000;
        setp = 12'h064; leadStop = 12'h096; stgOff = 7'h0A; minRun = 8'h02;
        fMode = FAULT_DISABLED_BACKUP; cfgSpd = 7'h32;
        tick(20);
        reset_n <= 1'b1;
        tick(1);
        note(0, 12'h04B); note(2, 12'h04B); note(3, 12'h000); note(4, 12'h000);
        p = 12'h04B;
        for (int i = 0; i < 4; i++)
        begin
            pulse(i);
            p = p + 12'(steps[i]);
            note(0, p); note(1, 12'h04B);
        end
        pulse(0); pulse(4);
        note(1, 12'h050);
        pulse(5);
        note(0, 12'h04B);
        pulse(9); pulse(7);
        note(1, 12'h04B); note(3, 12'h001);
        pulse(1); pulse(4); pulse(6);
        note(2, 12'h04C);
        for (int k = 0; k < PUMPS; k++)
            accel[k] <= 7'(1 + ($unsigned($random(seed)) % 100));
        level <= 12'h0C8 + 12'($unsigned($random(seed)) % 50);
        tick(2);
        note(4, 12'h001);
        settle({14'h0000, 7'h3C}, {14'h0000, 7'h7F});
        tick(1);
        note(5, 12'h03C); note(4, 12'h001); note(8, 12'h03C);
        hand <= 3'b010;
        tick(2);
        note(4, 12'h003);
        settle({7'h00, 7'h4C, 7'h4C}, {7'h00, 7'h7F, 7'h7F});
        note(5, 12'h04C); note(6, 12'h04C); note(7, 12'h000);
        hand <= 3'b000;
        level <= 12'h064;
        tick(3);
        note(4, 12'h000); note(5, 12'h000); note(6, 12'h000);
        hiF <= 1'b1;
        tick(2);
        note(4, 12'h007);
        hiF <= 1'b0; loEn <= 1'b1; loF <= 1'b0;
        tick(2);
        note(4, 12'h000); note(6, 12'h000); note(7, 12'h000);
        fMode <= FAULT_FLOATS; hiF <= 1'b1;
        tick(2);
        note(4, 12'h000);
        fMode <= FAULT_DISABLED_BACKUP; hiF <= 1'b0; loF <= 1'b1;
        stg <= STAGE_SPEED; fixedLag <= 1'b1;
        cfgSpd <= 7'h0B + 7'($unsigned($random(seed)) % 90);
        pulse(8);
        note(0, 12'(cfgSpd)); note(1, 12'(cfgSpd)); note(2, 12'(cfgSpd));
        level <= 12'h1A0;
        settle({cfgSpd, 7'h3C, 7'h3C}, '1);
        note(4, 12'h007); note(5, 12'h03C); note(7, 12'(cfgSpd));
        tick(8);
        minS <= 7'h05; level <= setp;
        tick(4);
        note(4, 12'h004); note(5, 12'h000); note(7, 12'(cfgSpd));
        tele <= 3'b001;
        settle({3{cfgSpd}}, {7'h7F, 7'h00, 7'h7F});
        note(4, 12'h005); note(5, 12'(cfgSpd));
        pulse(10);
        tick(1);
        note(3, 12'h000); note(4, 12'h000);
        tele <= 3'b000; fixedLag <= 1'b0; stg <= STAGE_LEVEL;
        pulse(9);
        pulse(11);
        note(3, 12'h000);
        note(0, 12'h04B); note(1, 12'h04B); note(2, 12'h04B);
        tick(2);
        give_verdict();
    end
endmodule

// >>> vfd_speed_pkg.sv
// constants and types for the pump speed and staging controller
// assumes one 100 MHz clock and percent-scaled speed words
package vfd_speed_pkg;

    // ------------------------------------------------------------
    // widths and sizes
    // ------------------------------------------------------------
    localparam int SPEED_W   = 7;
    localparam int LEVEL_W   = 12;
    localparam int PUMPS     = 3;
    localparam int RUNSEC_W  = 8;
    localparam int SECCNT_W  = 27;
    localparam int ACCCNT_W  = 3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 10;
    localparam int SECOND_NS        = 1_000_000_000;
    localparam int SECOND_CYCLES    = SECOND_NS / CLK_PERIOD_NS;
    localparam int ACCEL_INTERVAL_S = 5;

    // ------------------------------------------------------------
    // speed values (percent of full scale)
    // ------------------------------------------------------------
    localparam logic [SPEED_W-1:0] SPEED_ZERO   = 7'h00;
    localparam logic [SPEED_W-1:0] SPEED_FULL   = 7'h64;
    localparam logic [SPEED_W-1:0] OVERRIDE_RST = 7'h4B;
    localparam logic [SPEED_W-1:0] STEP_COARSE  = 7'h05;
    localparam logic [SPEED_W-1:0] STEP_FINE    = 7'h01;
    localparam logic               DRIVE_RST    = 1'h0;

    typedef enum logic [1:0] {FAULT_DISABLED_BACKUP, FAULT_FLOATS, FAULT_HOLD} faultMode_t;
    typedef enum logic {STAGE_LEVEL, STAGE_SPEED} staging_t;

endpackage
